/* rmsel_cfg.svh */
// constants for the remappable input selector
`ifndef RMSEL_CFG_SVH
`define RMSEL_CFG_SVH

// apb geometry
`define RMSEL_ADDR_W      8
`define RMSEL_DATA_W      32
`define RMSEL_STRB_W      4

// register byte offsets
`define RMSEL_OFF_FAULT   8'h00
`define RMSEL_OFF_CMPF    8'h04
`define RMSEL_OFF_UART1   8'h08
`define RMSEL_OFF_UART2   8'h0C
`define RMSEL_OFF_SPI2    8'h10
`define RMSEL_OFF_SS2     8'h14
`define RMSEL_OFF_CAN1    8'h18
`define RMSEL_OFF_SYNC1   8'h1C
`define RMSEL_OFF_DTCMP1  8'h20

// selector field geometry and byte lanes
`define RMSEL_SEL_W       8
`define RMSEL_LANE_LO     1'b0
`define RMSEL_LANE_HI     1'b1
`define RMSEL_LO_LSB      0
`define RMSEL_HI_LSB      8
`define RMSEL_SEL_RESET   8'h00

// selector codes
`define RMSEL_CODE_GND    8'h00
`define RMSEL_CODE_COMPARATOR_ONE_OUT   8'h01
`define RMSEL_CODE_TOP    8'hB5
`define RMSEL_CODE_SPACE  256
`define RMSEL_PIN_MIN     2
`define RMSEL_PIN_MAX     181
`define RMSEL_PIN_CNT     180
`define RMSEL_PAD_CNT     74

// channel numbering
`define RMSEL_NUM_CH      11
`define RMSEL_CH_PWM_FAULT_ONE_IN     0
`define RMSEL_CH_PWM_FAULT_TWO_IN     1
`define RMSEL_CH_COMPARE_FAULT_A_IN     2
`define RMSEL_CH_UART_ONE_RX_IN     3
`define RMSEL_CH_UART_TWO_RX_IN     4
`define RMSEL_CH_SPI_TWO_CLOCK_IN     5
`define RMSEL_CH_SPI_TWO_DATA_IN     6
`define RMSEL_CH_SS2      7
`define RMSEL_CH_CAN_ONE_RX_IN     8
`define RMSEL_CH_SYNC1    9
`define RMSEL_CH_DTCMP1   10

`endif

/* rmsel_pkg.sv */
// types for the remappable input selector
`include "rmsel_cfg.svh"
package rmsel_pkg;

    // bus answer phase
    typedef enum logic {
        phIdle,
        phAnswer
    } rmsel_phase_t;

    // whole state of the selector block
    typedef struct packed {
        logic [`RMSEL_NUM_CH-1:0][`RMSEL_SEL_W-1:0] sel;
        logic [`RMSEL_NUM_CH-1:0]                   route;
        rmsel_phase_t                               phase;
        logic                                       ready;
        logic                                       slvErr;
        logic [`RMSEL_DATA_W-1:0]                   rdata;
    } rmsel_state_t;

endpackage

/* rmsel_top.sv */
// apb-programmed input pin selector for eleven peripheral inputs
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rmsel_cfg.svh"

module rmsel_top (
    input  wire logic                                       clk,
    input  wire logic                                       rst_n,
    input  wire logic                                       psel,
    input  wire logic                                       penable,
    input  wire logic                                       pwrite,
    input  wire logic [`RMSEL_ADDR_W-1:0]                   paddr,
    input  wire logic [`RMSEL_DATA_W-1:0]                   pwdata,
    input  wire logic [`RMSEL_STRB_W-1:0]                   pstrb,
    output logic      [`RMSEL_DATA_W-1:0]                   prdata,
    output logic                                            pready,
    output logic                                            pslverr,
    input  wire logic [`RMSEL_PIN_MAX:`RMSEL_PIN_MIN]       remappable_pin,
    input  wire logic                                       comparator_one_out,
    output logic                                            pwm_fault_one_in,
    output logic                                            pwm_fault_two_in,
    output logic                                            compare_fault_a_in,
    output logic                                            uart_one_rx_in,
    output logic                                            uart_two_rx_in,
    output logic                                            spi_two_clock_in,
    output logic                                            spi_two_data_in,
    output logic                                            spi_two_select_in_n,
    output logic                                            can_one_rx_in,
    output logic                                            pwm_sync_one_in,
    output logic                                            deadtime_comp_one_in
);
    import rmsel_pkg::*;

    // register offset that owns each channel
    localparam logic [`RMSEL_ADDR_W-1:0] CH_OFF [`RMSEL_NUM_CH] = '{
        `RMSEL_OFF_FAULT,
        `RMSEL_OFF_FAULT,
        `RMSEL_OFF_CMPF,
        `RMSEL_OFF_UART1,
        `RMSEL_OFF_UART2,
        `RMSEL_OFF_SPI2,
        `RMSEL_OFF_SPI2,
        `RMSEL_OFF_SS2,
        `RMSEL_OFF_CAN1,
        `RMSEL_OFF_SYNC1,
        `RMSEL_OFF_DTCMP1
    };

    // byte lane that holds each channel's field
    localparam logic CH_HI [`RMSEL_NUM_CH] = '{
        `RMSEL_LANE_LO,
        `RMSEL_LANE_HI,
        `RMSEL_LANE_LO,
        `RMSEL_LANE_LO,
        `RMSEL_LANE_LO,
        `RMSEL_LANE_HI,
        `RMSEL_LANE_LO,
        `RMSEL_LANE_LO,
        `RMSEL_LANE_LO,
        `RMSEL_LANE_HI,
        `RMSEL_LANE_HI
    };

    rmsel_state_t                     stateReg;
    rmsel_state_t                     stateNext;
    logic [`RMSEL_CODE_SPACE-1:0]     codeSpace;
    logic [`RMSEL_NUM_CH-1:0]         muxOut;
    logic [`RMSEL_NUM_CH-1:0]         chHit;
    logic [`RMSEL_NUM_CH-1:0]         chWrite;
    logic                             setupPhase;
    logic                             accessDone;

    // code space: 0 ground, 1 comparator, pins, then unlisted codes low
    // ground code
    assign codeSpace = {
        {`RMSEL_PAD_CNT{1'b0}},
        remappable_pin,
        comparator_one_out,
        1'b0
    };

    // apb phase decode
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && stateReg.ready && (stateReg.phase == phAnswer);

    // per channel decode and source mux
    genvar c;
    generate
        for (c = 0; c < `RMSEL_NUM_CH; c++) begin : gChan
            assign chHit[c] = (paddr == CH_OFF[c]);
            assign chWrite[c] = accessDone && pwrite && chHit[c] && pstrb[CH_HI[c]];
            // code indexes pin, comparator or ground
            assign muxOut[c] = codeSpace[stateReg.sel[c]];
        end
    endgenerate

    // next state: selectors, routed inputs and bus answer
    always_comb begin
        stateNext = stateReg;
        // registered route follows the stored selector
        stateNext.route = muxOut;
        for (int i = 0; i < `RMSEL_NUM_CH; i++) begin
            if (chWrite[i]) begin
                if (CH_HI[i]) begin
                    stateNext.sel[i] = pwdata[`RMSEL_HI_LSB +: `RMSEL_SEL_W];
                end else begin
                    stateNext.sel[i] = pwdata[`RMSEL_LO_LSB +: `RMSEL_SEL_W];
                end
            end
        end
        stateNext.ready  = setupPhase;
        stateNext.phase  = setupPhase ? phAnswer : phIdle;
        stateNext.slvErr = 1'b0;
        stateNext.rdata  = '0;
        if (setupPhase) begin
            stateNext.slvErr = ~|chHit;
            if (!pwrite) begin
                for (int i = 0; i < `RMSEL_NUM_CH; i++) begin
                    if (chHit[i] && CH_HI[i]) begin
                        stateNext.rdata[`RMSEL_HI_LSB +: `RMSEL_SEL_W] = stateReg.sel[i];
                    end else if (chHit[i]) begin
                        stateNext.rdata[`RMSEL_LO_LSB +: `RMSEL_SEL_W] = stateReg.sel[i];
                    end
                end
            end
        end
    end

    // state register
    // all selectors clear at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    // outputs straight from the state register
    assign prdata               = stateReg.rdata;
    assign pready               = stateReg.ready;
    assign pslverr              = stateReg.slvErr;
    assign pwm_fault_one_in     = stateReg.route[`RMSEL_CH_PWM_FAULT_ONE_IN];
    assign pwm_fault_two_in     = stateReg.route[`RMSEL_CH_PWM_FAULT_TWO_IN];
    assign compare_fault_a_in   = stateReg.route[`RMSEL_CH_COMPARE_FAULT_A_IN];
    assign uart_one_rx_in       = stateReg.route[`RMSEL_CH_UART_ONE_RX_IN];
    assign uart_two_rx_in       = stateReg.route[`RMSEL_CH_UART_TWO_RX_IN];
    assign spi_two_clock_in     = stateReg.route[`RMSEL_CH_SPI_TWO_CLOCK_IN];
    assign spi_two_data_in      = stateReg.route[`RMSEL_CH_SPI_TWO_DATA_IN];
    assign spi_two_select_in_n  = stateReg.route[`RMSEL_CH_SS2];
    assign can_one_rx_in        = stateReg.route[`RMSEL_CH_CAN_ONE_RX_IN];
    assign pwm_sync_one_in      = stateReg.route[`RMSEL_CH_SYNC1];
    assign deadtime_comp_one_in = stateReg.route[`RMSEL_CH_DTCMP1];

    // checks on routing, field layout and bus answer
    default clocking cbMain @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_top_pin_route: assert property (
        stateReg.sel[`RMSEL_CH_PWM_FAULT_ONE_IN] == `RMSEL_CODE_TOP
        |=> pwm_fault_one_in == $past(remappable_pin[`RMSEL_PIN_MAX])
    ) else $error("top pin code did not route the top pin");

    a_comp_route: assert property (
        stateReg.sel[`RMSEL_CH_UART_ONE_RX_IN] == `RMSEL_CODE_COMPARATOR_ONE_OUT
        |=> uart_one_rx_in == $past(comparator_one_out)
    ) else $error("comparator code did not route comparator one");

    a_ground_tie: assert property (
        stateReg.sel[`RMSEL_CH_SS2] == `RMSEL_CODE_GND |=> !spi_two_select_in_n
    ) else $error("ground code did not hold the input low");

    a_fault_fields: assert property (
        accessDone && pwrite && paddr == `RMSEL_OFF_FAULT && pstrb[1:0] == 2'b11
        |=> stateReg.sel[`RMSEL_CH_PWM_FAULT_TWO_IN] == $past(pwdata[15:8])
            && stateReg.sel[`RMSEL_CH_PWM_FAULT_ONE_IN] == $past(pwdata[7:0])
    ) else $error("fault fields not stored in their lanes");

    a_uart_readback: assert property (
        accessDone && !pwrite && paddr == `RMSEL_OFF_UART1
        |-> prdata == {24'h00_0000, stateReg.sel[`RMSEL_CH_UART_ONE_RX_IN]}
    ) else $error("uart one readback wrong or upper bits set");

    a_spi_readback: assert property (
        accessDone && !pwrite && paddr == `RMSEL_OFF_SPI2
        |-> prdata[15:0] == {stateReg.sel[`RMSEL_CH_SPI_TWO_CLOCK_IN], stateReg.sel[`RMSEL_CH_SPI_TWO_DATA_IN]}
    ) else $error("spi two readback lanes wrong");

    a_sync_readback: assert property (
        accessDone && !pwrite && paddr == `RMSEL_OFF_SYNC1
        |-> prdata == {16'h0000, stateReg.sel[`RMSEL_CH_SYNC1], 8'h00}
    ) else $error("sync one readback wrong or lower byte set");

    a_upper_ignore: assert property (
        accessDone && pwrite && paddr == `RMSEL_OFF_CAN1 && !pstrb[0]
        |=> $stable(stateReg.sel[`RMSEL_CH_CAN_ONE_RX_IN])
    ) else $error("upper lane write changed the can one field");

    a_reset_clear: assert property (
        !$past(rst_n) |-> stateReg.sel == '0 && stateReg.route == '0
    ) else $error("selectors not clear after reset");

    a_unlisted_low: assert property (
        stateReg.sel[`RMSEL_CH_CAN_ONE_RX_IN] > `RMSEL_CODE_TOP |=> !can_one_rx_in
    ) else $error("unlisted code did not read low");

    a_redirect_next: assert property (
        accessDone && pwrite && paddr == `RMSEL_OFF_DTCMP1 && pstrb[1]
        && pwdata[15:8] == `RMSEL_CODE_GND
        |-> ##2 !deadtime_comp_one_in
    ) else $error("new selector not in force two edges after write");

    a_answer_next: assert property (
        setupPhase |=> pready ##1 !pready
    ) else $error("bus answer not one cycle after setup");

    // readback layout of the six registers not checked above
    a_fault_readback: assert property (
        accessDone && !pwrite && paddr == `RMSEL_OFF_FAULT
        |-> prdata == {16'h0000, stateReg.sel[`RMSEL_CH_PWM_FAULT_TWO_IN], stateReg.sel[`RMSEL_CH_PWM_FAULT_ONE_IN]}
    ) else $error("fault register readback wrong or upper bits set");

    a_cmpf_readback: assert property (
        accessDone && !pwrite && paddr == `RMSEL_OFF_CMPF
        |-> prdata == {24'h00_0000, stateReg.sel[`RMSEL_CH_COMPARE_FAULT_A_IN]}
    ) else $error("compare fault readback wrong or upper bits set");

    a_uart_two_readback: assert property (
        accessDone && !pwrite && paddr == `RMSEL_OFF_UART2
        |-> prdata == {24'h00_0000, stateReg.sel[`RMSEL_CH_UART_TWO_RX_IN]}
    ) else $error("uart two readback wrong or upper bits set");

    a_select_readback: assert property (
        accessDone && !pwrite && paddr == `RMSEL_OFF_SS2
        |-> prdata == {24'h00_0000, stateReg.sel[`RMSEL_CH_SS2]}
    ) else $error("spi two select readback wrong or upper bits set");

    a_can_readback: assert property (
        accessDone && !pwrite && paddr == `RMSEL_OFF_CAN1
        |-> prdata == {24'h00_0000, stateReg.sel[`RMSEL_CH_CAN_ONE_RX_IN]}
    ) else $error("can one readback wrong or upper bits set");

    a_dtcmp_readback: assert property (
        accessDone && !pwrite && paddr == `RMSEL_OFF_DTCMP1
        |-> prdata == {16'h0000, stateReg.sel[`RMSEL_CH_DTCMP1], 8'h00}
    ) else $error("dead-time readback wrong or lower byte set");

    // field storage and untouched selectors
    a_spi_fields: assert property (
        accessDone && pwrite && paddr == `RMSEL_OFF_SPI2 && pstrb[1:0] == 2'b11
        |=> stateReg.sel[`RMSEL_CH_SPI_TWO_CLOCK_IN] == $past(pwdata[15:8])
            && stateReg.sel[`RMSEL_CH_SPI_TWO_DATA_IN] == $past(pwdata[7:0])
    ) else $error("spi two fields not stored in their lanes");

    a_sync_field: assert property (
        accessDone && pwrite && paddr == `RMSEL_OFF_SYNC1 && pstrb[1]
        |=> stateReg.sel[`RMSEL_CH_SYNC1] == $past(pwdata[15:8])
    ) else $error("sync one field not taken from the upper lane");

    a_cmpf_field: assert property (
        accessDone && pwrite && paddr == `RMSEL_OFF_CMPF && pstrb[0]
        |=> stateReg.sel[`RMSEL_CH_COMPARE_FAULT_A_IN] == $past(pwdata[7:0])
    ) else $error("compare fault field not taken from the lower lane");

    a_write_only: assert property (
        !(accessDone && pwrite) |=> $stable(stateReg.sel)
    ) else $error("selector changed without a completed write");

    a_others_kept: assert property (
        accessDone && pwrite && paddr == `RMSEL_OFF_UART2
        |=> $stable(stateReg.sel[`RMSEL_CH_UART_ONE_RX_IN]) && $stable(stateReg.sel[`RMSEL_CH_CAN_ONE_RX_IN])
    ) else $error("write to uart two disturbed other selectors");

    // routing on further channels
    a_top_pin_clock: assert property (
        stateReg.sel[`RMSEL_CH_SPI_TWO_CLOCK_IN] == `RMSEL_CODE_TOP
        |=> spi_two_clock_in == $past(remappable_pin[`RMSEL_PIN_MAX])
    ) else $error("top pin code did not route the top pin to spi two clock");

    a_top_pin_data: assert property (
        stateReg.sel[`RMSEL_CH_SPI_TWO_DATA_IN] == `RMSEL_CODE_TOP
        |=> spi_two_data_in == $past(remappable_pin[`RMSEL_PIN_MAX])
    ) else $error("top pin code did not route the top pin to spi two data");

    a_comp_fault: assert property (
        stateReg.sel[`RMSEL_CH_PWM_FAULT_TWO_IN] == `RMSEL_CODE_COMPARATOR_ONE_OUT
        |=> pwm_fault_two_in == $past(comparator_one_out)
    ) else $error("comparator code did not route comparator one to fault two");

    a_comp_fault_a: assert property (
        stateReg.sel[`RMSEL_CH_COMPARE_FAULT_A_IN] == `RMSEL_CODE_COMPARATOR_ONE_OUT
        |=> compare_fault_a_in == $past(comparator_one_out)
    ) else $error("comparator code did not route comparator one to fault a");

    a_ground_can: assert property (
        stateReg.sel[`RMSEL_CH_CAN_ONE_RX_IN] == `RMSEL_CODE_GND |=> !can_one_rx_in
    ) else $error("ground code did not hold can one receive low");

    a_unlisted_sync: assert property (
        stateReg.sel[`RMSEL_CH_SYNC1] > `RMSEL_CODE_TOP |=> !pwm_sync_one_in
    ) else $error("unlisted code did not hold sync one low");

    a_unlisted_fault: assert property (
        stateReg.sel[`RMSEL_CH_PWM_FAULT_TWO_IN] > `RMSEL_CODE_TOP |=> !pwm_fault_two_in
    ) else $error("unlisted code did not hold fault two low");

    a_pin_code_two: assert property (
        stateReg.sel[`RMSEL_CH_UART_TWO_RX_IN] == 8'(`RMSEL_PIN_MIN)
        |=> uart_two_rx_in == $past(remappable_pin[`RMSEL_PIN_MIN])
    ) else $error("pin code two did not route the lowest pin");

    // bus answer shape
    a_error_reads_zero: assert property (
        pslverr |-> prdata == '0
    ) else $error("refused transfer returned data");

    a_idle_quiet: assert property (
        !pready |-> prdata == '0 && !pslverr
    ) else $error("read data or error shown outside the answer cycle");

    a_ready_after_setup: assert property (
        pready |-> $past(setupPhase)
    ) else $error("bus answer without a setup cycle before it");

    c_top_pin: cover property (
        stateReg.sel[`RMSEL_CH_PWM_FAULT_ONE_IN] == `RMSEL_CODE_TOP ##1 pwm_fault_one_in
    );

    c_comp_route: cover property (
        stateReg.sel[`RMSEL_CH_UART_ONE_RX_IN] == `RMSEL_CODE_COMPARATOR_ONE_OUT ##1 uart_one_rx_in
    );

    c_unmapped: cover property (
        accessDone && pslverr
    );

    c_write_read: cover property (
        accessDone && pwrite ##[1:4] accessDone && !pwrite
    );

    c_upper_ignored: cover property (
        accessDone && pwrite && !pstrb[0]
    );

endmodule

/* rmsel_pin_model.sv */
// pin and comparator levels feeding the selector
`timescale 1ns/1ps
`include "rmsel_cfg.svh"

module rmsel_pin_model (
    input  wire logic                                 clk,
    output logic [`RMSEL_PIN_MAX:`RMSEL_PIN_MIN]      pinLevel,
    output logic                                      cmpLevel
);
    int seed = 32'h72c9_392c;

    // known levels before the first edge
    initial begin
        pinLevel = '0;
        cmpLevel = 1'b0;
    end

    // levels move every cycle so a stale route shows up
    always @(posedge clk) begin
        pinLevel <= {pinLevel[180:2], ~pinLevel[181]} ^ 180'($unsigned($random(seed)));
        cmpLevel <= 1'($random(seed));
    end
endmodule

/* rmsel_top_tb.sv */
// self-checking bench for the input selector
`timescale 1ns/1ps
`include "rmsel_cfg.svh"

module rmsel_top_tb;
    import rmsel_pkg::*;
    localparam int         chReg  [`RMSEL_NUM_CH] = '{0, 0, 1, 2, 3, 4, 4, 5, 6, 7, 8};
    localparam bit         chHi   [`RMSEL_NUM_CH] = '{0, 1, 0, 0, 0, 1, 0, 0, 0, 1, 1};
    localparam logic [7:0] regOff [9] = '{`RMSEL_OFF_FAULT, `RMSEL_OFF_CMPF, `RMSEL_OFF_UART1,
        `RMSEL_OFF_UART2, `RMSEL_OFF_SPI2, `RMSEL_OFF_SS2, `RMSEL_OFF_CAN1, `RMSEL_OFF_SYNC1,
        `RMSEL_OFF_DTCMP1};
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = '0;
    logic [31:0]  pwdata = '0;
    logic [3:0]   pstrb = '0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [181:2] pinLevel;
    logic         cmpLevel;
    wire  [10:0]  outs;
    logic [7:0]   selShadow [`RMSEL_NUM_CH];
    logic [31:0]  rd;
    logic [31:0]  d;
    logic         err;
    logic [7:0]   lo;
    logic [7:0]   hi;
    logic [3:0]   s;
    int           regIdx;
    int           errors = 0;
    int           checked = 0;
    int           seed = 32'h72c9_392c;

    // 20 MHz clock
    always #25 clk = ~clk;

    rmsel_pin_model u_pins (.clk(clk), .pinLevel(pinLevel), .cmpLevel(cmpLevel));

    rmsel_top u_dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .remappable_pin(pinLevel), .comparator_one_out(cmpLevel),
        .pwm_fault_one_in(outs[0]), .pwm_fault_two_in(outs[1]), .compare_fault_a_in(outs[2]),
        .uart_one_rx_in(outs[3]), .uart_two_rx_in(outs[4]), .spi_two_clock_in(outs[5]),
        .spi_two_data_in(outs[6]), .spi_two_select_in_n(outs[7]), .can_one_rx_in(outs[8]),
        .pwm_sync_one_in(outs[9]), .deadtime_comp_one_in(outs[10])
    );

    // expected level of one routed input
    function automatic logic routeOf(logic [7:0] code, logic [181:2] p, logic c);
        if (code == `RMSEL_CODE_COMPARATOR_ONE_OUT) return c;
        if (code >= `RMSEL_PIN_MIN && code <= `RMSEL_PIN_MAX) return p[code];
        return 1'b0;
    endfunction

    // expected read word of one register
    function automatic logic [31:0] regExp(int r);
        logic [31:0] v;
        v = '0;
        for (int c = 0; c < `RMSEL_NUM_CH; c++)
            if (chReg[c] == r) v |= 32'(selShadow[c]) << (chHi[c] ? 8 : 0);
        return v;
    endfunction

    // corner codes first, then random ones
    function automatic logic [7:0] pick(int k);
        case (k)
            0: return `RMSEL_CODE_GND;
            1: return `RMSEL_CODE_COMPARATOR_ONE_OUT;
            2: return `RMSEL_CODE_TOP;
            3: return 8'hB6;
            4: return 8'h02;
            default: return 8'($random(seed));
        endcase
    endfunction

    task automatic cmpReg(logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmpErr(logic got, logic exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t slave error %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cmpOut(logic [10:0] got, logic [10:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t routed inputs %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one apb transfer, waits for pready; the watchdog bounds a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // outputs follow the levels sampled one edge earlier
    task automatic checkOuts();
        logic [181:2] p;
        logic         c;
        logic [10:0]  exp;
        @(negedge clk);
        p = pinLevel;
        c = cmpLevel;
        @(negedge clk);
        for (int k = 0; k < `RMSEL_NUM_CH; k++) exp[k] = routeOf(selShadow[k], p, c);
        cmpOut(outs, exp);
    endtask

    task automatic readAll();
        for (int r = 0; r < 9; r++) begin
            apb(1'b0, regOff[r], '0, '0, rd, err);
            cmpReg(rd, regExp(r));
            cmpErr(err, 1'b0);
        end
    endtask

    // main sequence
    initial begin
        for (int c = 0; c < `RMSEL_NUM_CH; c++) selShadow[c] = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        readAll();
        checkOuts();
        for (int i = 0; i < 72; i++) begin
            regIdx = i % 9;
            lo = pick(i / 9);
            hi = pick(i / 9 + 1);
            s = (i < 36) ? 4'hF : 4'($random(seed));
            d = {16'($random(seed)), hi, lo};
            apb(1'b1, regOff[regIdx], d, s, rd, err);
            cmpErr(err, 1'b0);
            for (int c = 0; c < `RMSEL_NUM_CH; c++)
                if (chReg[c] == regIdx && s[chHi[c]]) selShadow[c] = chHi[c] ? hi : lo;
            apb(1'b0, regOff[regIdx], '0, '0, rd, err);
            cmpReg(rd, regExp(regIdx));
            checkOuts();
        end
        // corners: ground to dead-time, pin code two, masked low lane
        apb(1'b1, `RMSEL_OFF_DTCMP1, 32'h0000_00FF, 4'hF, rd, err);
        cmpErr(err, 1'b0);
        apb(1'b1, `RMSEL_OFF_UART2, 32'h0000_FF02, 4'hF, rd, err);
        cmpErr(err, 1'b0);
        apb(1'b1, `RMSEL_OFF_CAN1, 32'h0000_0001, 4'h2, rd, err);
        cmpErr(err, 1'b0);
        selShadow[`RMSEL_CH_DTCMP1] = `RMSEL_CODE_GND;
        selShadow[`RMSEL_CH_UART_TWO_RX_IN] = 8'h02;
        checkOuts();
        // unmapped and misaligned places refuse
        apb(1'b1, 8'h24, '1, 4'hF, rd, err);
        cmpErr(err, 1'b1);
        apb(1'b0, 8'h24, '0, '0, rd, err);
        cmpReg(rd, 32'h0000_0000);
        cmpErr(err, 1'b1);
        apb(1'b1, 8'h01, '1, 4'hF, rd, err);
        cmpErr(err, 1'b1);
        readAll();
        // second reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int c = 0; c < `RMSEL_NUM_CH; c++) selShadow[c] = '0;
        checkOuts();
        readAll();
        summarize();
    end

    // watchdog
    initial begin
        #2_000_000;
        errors++;
        summarize();
    end
endmodule
